// file: ct_channel_model.sv
// Model of the current transformers and the second control output facing the qualifier.
// Assumes one clock; ticks come every GAP cycles while run is high.
`timescale 1ns/1ps
module ct_channel_model #(
	parameter GAP = 6 // Cycles between sampling ticks.
) (
	input wire hclk, // Clock.
	input wire hresetn, // Reset, active low.
	input wire run, // Lets the sampling ticks run.
	input wire [11:0] raw_one, // Reading for input one.
	input wire [11:0] raw_two, // Reading for input two.
	input wire on_two, // On state of output two.
	output reg sample_tick, // One-cycle sampling pulse.
	output wire [11:0] current_sense_input_one, // Reading one.
	output wire [11:0] current_sense_input_two, // Reading two.
	output wire control_output_two // Output two state.
);
	reg [3:0] gap_ff;
	assign current_sense_input_one = raw_one;
	assign current_sense_input_two = raw_two;
	assign control_output_two = on_two;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_ff <= 4'h0;
			sample_tick <= 1'b0;
		end else begin
			gap_ff <= (run && gap_ff != GAP - 1) ? gap_ff + 4'h1 : 4'h0;
			sample_tick <= run && gap_ff == GAP - 1;
		end
	end
endmodule // ct_channel_model

// file: hba_qual_defs.vh
// Constants for the heater-break alarm qualifier: register offsets, field layout, reset values and timing.
// Assumes inclusion by bare name from the design file; holds definitions only.
`ifndef HBA_QUAL_DEFS_VH
`define HBA_QUAL_DEFS_VH

// Register byte offsets on the AHB-Lite slave.
`define OFS_RATIO_ONE 8'h00
`define OFS_RATIO_TWO 8'h04
`define OFS_ASSIGN 8'h08
`define OFS_TYPE 8'h0C
`define OFS_DELAY 8'h10
`define OFS_SETV_ONE 8'h14
`define OFS_SETV_TWO 8'h18
`define OFS_STATUS 8'h1C
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_CLR 8'h24
`define OFS_IRQ_EN 8'h28

// Field positions.
`define ASSIGN_ONE_LSB 0
`define ASSIGN_TWO_LSB 4
`define ASSIGN_W 3
`define DELAY_ONE_LSB 0
`define DELAY_TWO_LSB 8
`define DELAY_W 8
`define RATIO_W 14

// Assignment codes.
`define ASSIGN_NONE 3'h0
`define ASSIGN_OUT_ONE 3'h1
`define ASSIGN_OUT_TWO 3'h2

// Alarm types.
`define TYPE_A 1'b0
`define TYPE_B 1'b1

// Reset values.
`define RST_RATIO 14'h0320
`define RST_ASSIGN_ONE 3'h1
`define RST_ASSIGN_TWO 3'h0
`define RST_TYPE 2'h0
`define RST_DELAY 8'h05

// Timing: the alarm sample is taken on every second input sampling tick.
`define INPUT_PERIOD_MS 100
`define ALARM_SAMPLE_MS 200
`define ALARM_TICKS (`ALARM_SAMPLE_MS / `INPUT_PERIOD_MS)

// Full-output figure of the manipulated variable, in percent.
`define MV_FULL 7'h64

`endif

// file: hba_qual_props.sv
// Concurrent checks on the ports of the heater-break alarm qualifier.
// Assumes it is bound onto heater_break_alarm_qualifier and sees only its ports.
`timescale 1ns/1ps
module hba_qual_props (
	input wire hclk, // Clock.
	input wire hresetn, // Reset, active low.
	input wire hsel, // Slave select.
	input wire [1:0] htrans, // Transfer type.
	input wire hwrite, // Write strobe.
	input wire hready, // Bus ready.
	input wire hreadyout, // Slave ready.
	input wire hresp, // Response.
	input wire [31:0] hrdata, // Read data.
	input wire sample_tick, // Sampling tick.
	input wire current_sense_fitted, // Option fitted.
	input wire digital_output_fitted, // Digital output fitted.
	input wire heater_fault_alarm_one, // Alarm one.
	input wire heater_fault_alarm_two, // Alarm two.
	input wire alarm_to_output_two_ff, // Alarm onto output two.
	input wire alarm_to_digital_ff // Alarm onto digital output.
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ready;
		hreadyout == 1'b1;
	endproperty
	a_ready: assert property (p_ready) else $error("slave inserted a wait state");
	property p_resp;
		hresp == 1'b0;
	endproperty
	a_resp: assert property (p_resp) else $error("response not OKAY");
	property p_rdata;
		hrdata != 32'h0 |-> $past(hsel && htrans[1] && hready && !hwrite);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside a read data phase");
	property p_rise_one;
		$rose(heater_fault_alarm_one) |-> $past(sample_tick && current_sense_fitted);
	endproperty
	a_rise_one: assert property (p_rise_one) else $error("alarm one rose without a sample");
	property p_rise_two;
		$rose(heater_fault_alarm_two) |-> $past(sample_tick && current_sense_fitted);
	endproperty
	a_rise_two: assert property (p_rise_two) else $error("alarm two rose without a sample");
	property p_unfit;
		!current_sense_fitted |=> !heater_fault_alarm_one && !heater_fault_alarm_two;
	endproperty
	a_unfit: assert property (p_unfit) else $error("alarm held without the sense option");
	property p_digital;
		alarm_to_digital_ff == $past(digital_output_fitted && (heater_fault_alarm_one || heater_fault_alarm_two));
	endproperty
	a_digital: assert property (p_digital) else $error("digital output drive wrong");
	property p_out_two;
		alarm_to_output_two_ff |-> $past(heater_fault_alarm_one || heater_fault_alarm_two);
	endproperty
	a_out_two: assert property (p_out_two) else $error("output two driven with no alarm");
endmodule // hba_qual_props

bind heater_break_alarm_qualifier hba_qual_props hba_qual_props_i (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .sample_tick, .current_sense_fitted, .digital_output_fitted,
	.heater_fault_alarm_one, .heater_fault_alarm_two, .alarm_to_output_two_ff, .alarm_to_digital_ff);

// file: heater_break_alarm_qualifier.v
// Heater-break alarm qualifier with an AHB-Lite register slave and one level interrupt.
// Assumes hclk at 25 MHz, a one-cycle sample_tick per input sampling period, and inputs synchronous to hclk.
// The block has no clock enable; the alarm logic is paced by sample_tick instead.
// Overview of operation
// [R1] An alarm rises only after the scaled current stays in the alarm range for the programmed count of samples.
// [R2] The alarm delay is the count times the alarm sampling time, which is two input sampling periods.
// [R3] Each current reading is multiplied by its programmable turns ratio, default 800, range 0 to 9999; the register accepts any 14-bit value, up to 16383.
// [R4] Assignment code 0 disables the alarm, 1 selects the first control output and 2 the second.
// [R5] Input one always drives alarm one and input two alarm two, each following its input's assignment.
// [R6] Both inputs may be assigned to the same control output for three-phase monitoring.
// [R7] Type code 0 is type A for time-proportional outputs and 1 is type B for continuous outputs.
// [R8] Nothing acts without the current-sense option, and alarms leave only via output two or the digital output.
// [R9] Type A compares the measured current directly against the alarm set value.
// [R10] Type B compares the current with an expectation proportional to the manipulated output.
// [R11] Writing an assignment sets the type from the kind of output chosen, and no output forces type A.
// [R12] An out-of-range sample restarts the count, and a count of zero alarms on the first in-range sample.
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "hba_qual_defs.vh"

module heater_break_alarm_qualifier #(
	parameter CT_W = 12, // Width of a raw current-sense reading.
	parameter MV_W = 7 // Width of a manipulated output value in percent.
) (
	input wire hclk, // Bus and block clock.
	input wire hresetn, // Asynchronous reset, active low.
	input wire hsel, // AHB slave select.
	input wire [31:0] haddr, // AHB address.
	input wire [1:0] htrans, // AHB transfer type.
	input wire hwrite, // AHB write strobe.
	input wire [2:0] hsize, // AHB transfer size.
	input wire [31:0] hwdata, // AHB write data.
	input wire hready, // AHB bus ready.
	output wire hreadyout, // AHB slave ready.
	output wire hresp, // AHB response, always OKAY.
	output wire [31:0] hrdata, // AHB read data.

	input wire sample_tick, // One-cycle pulse per input sampling period.
	input wire [CT_W-1:0] current_sense_input_one, // Raw reading of the first current transformer.
	input wire [CT_W-1:0] current_sense_input_two, // Raw reading of the second current transformer.
	input wire control_output_one, // Present on state of the first control output.
	input wire control_output_two, // Present on state of the second control output.
	input wire [MV_W-1:0] mv_one, // Manipulated output of the first control output.
	input wire [MV_W-1:0] mv_two, // Manipulated output of the second control output.
	input wire out_one_continuous, // First control output is a continuous type.
	input wire out_two_continuous, // Second control output is a continuous type.
	input wire current_sense_fitted, // The current-sense option is fitted.
	input wire digital_output_fitted, // The optional digital output is fitted.

	output wire heater_fault_alarm_one, // Qualified alarm of input one.
	output wire heater_fault_alarm_two, // Qualified alarm of input two.
	output reg alarm_to_output_two_ff, // Alarm drive onto the second control output.
	output reg alarm_to_digital_ff, // Alarm drive onto the optional digital output.
	output wire irq // Level interrupt, high while an enabled status bit is set.
);

	// Products are carried at full width, so no compare ever loses its top bits.
	localparam SC_W = CT_W + `RATIO_W;
	localparam PR_W = SC_W + MV_W;

	reg [`RATIO_W-1:0] ratio_one_ff;
	reg [`RATIO_W-1:0] ratio_two_ff;
	reg [`ASSIGN_W-1:0] assign_one_ff;
	reg [`ASSIGN_W-1:0] assign_two_ff;
	reg [1:0] type_ff;
	reg [`DELAY_W-1:0] delay_one_ff;
	reg [`DELAY_W-1:0] delay_two_ff;
	reg [SC_W-1:0] setv_one_ff;
	reg [SC_W-1:0] setv_two_ff;
	reg [1:0] irq_stat_ff;
	reg [1:0] irq_en_ff;

	reg [31:0] hrdata_ff;
	reg wr_pend_ff;
	reg [7:0] wr_addr_ff;
	reg phase_ff;

	wire [1:0] alarm_vec;
	wire [2*`DELAY_W-1:0] cnt_vec;
	wire [1:0] rise_vec;
	wire alarm_tick;
	wire addr_phase;
	wire [7:0] ofs;
	wire [1:0] irq_clr;
	wire [1:0] type_from_one;
	wire [1:0] type_from_two;

	// The slave never stretches a transfer, so hreadyout is tied high and every response is OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign addr_phase = hsel & htrans[1] & hready;
	// Only the low byte of the address is decoded, so the map repeats every 256 bytes.
	assign ofs = haddr[7:0];

	// The alarm sample falls on every second input tick, so the delay is count times two periods.
	// The phase starts at zero, so the first tick after reset is never judged.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ff <= 1'b0;
		end else if (sample_tick) begin
			phase_ff <= ~phase_ff; // see [R2]
		end
	end
	assign alarm_tick = sample_tick & phase_ff; // see [R2]

	// Type follows the kind of output an assignment selects; codes outside 1 and 2 count as no output.
	function type_for;
		input [`ASSIGN_W-1:0] code;
		begin
			case (code)
				`ASSIGN_OUT_ONE: begin
					type_for = out_one_continuous ? `TYPE_B : `TYPE_A;
				end
				`ASSIGN_OUT_TWO: begin
					type_for = out_two_continuous ? `TYPE_B : `TYPE_A;
				end
				default: begin
					type_for = `TYPE_A;
				end
			endcase
		end
	endfunction

	// An assignment write rewrites both type bits; a later type write can still override them.
	assign type_from_one = {1'b0, type_for(hwdata[`ASSIGN_ONE_LSB +: `ASSIGN_W])}; // see [R11]
	assign type_from_two = {type_for(hwdata[`ASSIGN_TWO_LSB +: `ASSIGN_W]), 1'b0}; // see [R11]
	// A clear acts only in the data phase of a write to the clear register.
	assign irq_clr = (wr_pend_ff && wr_addr_ff == `OFS_IRQ_CLR) ? hwdata[1:0] : 2'h0;

	// Register writes land in the data phase; there is never a wait state.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			ratio_one_ff <= `RST_RATIO;
			ratio_two_ff <= `RST_RATIO;
			assign_one_ff <= `RST_ASSIGN_ONE;
			assign_two_ff <= `RST_ASSIGN_TWO;
			type_ff <= `RST_TYPE;
			delay_one_ff <= `RST_DELAY;
			delay_two_ff <= `RST_DELAY;
			setv_one_ff <= {SC_W{1'b0}};
			setv_two_ff <= {SC_W{1'b0}};
			irq_en_ff <= 2'h0;
		end else begin
			wr_pend_ff <= addr_phase & hwrite;
			wr_addr_ff <= ofs;
			if (wr_pend_ff) begin
				case (wr_addr_ff)
					`OFS_RATIO_ONE: begin
						ratio_one_ff <= hwdata[`RATIO_W-1:0]; // see [R3]
					end
					`OFS_RATIO_TWO: begin
						ratio_two_ff <= hwdata[`RATIO_W-1:0]; // see [R3]
					end
					`OFS_ASSIGN: begin
						assign_one_ff <= hwdata[`ASSIGN_ONE_LSB +: `ASSIGN_W]; // see [R4]
						assign_two_ff <= hwdata[`ASSIGN_TWO_LSB +: `ASSIGN_W]; // see [R4]
						type_ff <= type_from_one | type_from_two; // see [R11]
					end
					`OFS_TYPE: begin
						type_ff <= hwdata[1:0]; // see [R7]
					end
					`OFS_DELAY: begin
						delay_one_ff <= hwdata[`DELAY_ONE_LSB +: `DELAY_W]; // see [R1]
						delay_two_ff <= hwdata[`DELAY_TWO_LSB +: `DELAY_W]; // see [R1]
					end
					`OFS_SETV_ONE: begin
						setv_one_ff <= hwdata[SC_W-1:0];
					end
					`OFS_SETV_TWO: begin
						setv_two_ff <= hwdata[SC_W-1:0];
					end
					`OFS_IRQ_EN: begin
						irq_en_ff <= hwdata[1:0];
					end
					default: begin
						// Read-only and unmapped offsets ignore writes.
						irq_en_ff <= irq_en_ff;
					end
				endcase
			end
		end
	end

	// Read data is registered in the address phase so it stands during the data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			case (ofs)
				`OFS_RATIO_ONE: begin
					hrdata_ff <= {18'h00000, ratio_one_ff};
				end
				`OFS_RATIO_TWO: begin
					hrdata_ff <= {18'h00000, ratio_two_ff};
				end
				`OFS_ASSIGN: begin
					hrdata_ff <= {25'h0000000, assign_two_ff, 1'b0, assign_one_ff};
				end
				`OFS_TYPE: begin
					hrdata_ff <= {30'h00000000, type_ff};
				end
				`OFS_DELAY: begin
					hrdata_ff <= {16'h0000, delay_two_ff, delay_one_ff};
				end
				`OFS_SETV_ONE: begin
					hrdata_ff <= {{(32-SC_W){1'b0}}, setv_one_ff};
				end
				`OFS_SETV_TWO: begin
					hrdata_ff <= {{(32-SC_W){1'b0}}, setv_two_ff};
				end
				`OFS_STATUS: begin
					hrdata_ff <= {12'h000, cnt_vec, 2'h0, alarm_vec};
				end
				`OFS_IRQ_STAT: begin
					hrdata_ff <= {30'h00000000, irq_stat_ff};
				end
				`OFS_IRQ_EN: begin
					hrdata_ff <= {30'h00000000, irq_en_ff};
				end
				default: begin
					hrdata_ff <= 32'h00000000;
				end
			endcase
		end else begin
			// Zero outside a read data phase keeps the read bus quiet between transfers.
			hrdata_ff <= 32'h00000000;
		end
	end

	// Per-channel qualification. Input i is bound to alarm i for good; only its output choice moves.
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_chan
			wire [CT_W-1:0] raw;
			wire [`RATIO_W-1:0] ratio;
			wire [`ASSIGN_W-1:0] asg;
			wire [`DELAY_W-1:0] need;
			wire [SC_W-1:0] setv;
			wire [SC_W-1:0] scaled;
			wire [PR_W-1:0] meas_pct;
			wire [PR_W-1:0] expect_pct;
			wire [MV_W-1:0] mv;
			wire active;
			wire out_on;
			wire in_range;
			wire [`DELAY_W:0] cnt_inc;

			reg [`DELAY_W-1:0] cnt_ff;
			reg alarm_ff;
			reg alarm_d_ff;

			assign raw = (i == 0) ? current_sense_input_one : current_sense_input_two; // see [R5]
			assign ratio = (i == 0) ? ratio_one_ff : ratio_two_ff;
			assign asg = (i == 0) ? assign_one_ff : assign_two_ff; // see [R5]
			assign need = (i == 0) ? delay_one_ff : delay_two_ff;
			assign setv = (i == 0) ? setv_one_ff : setv_two_ff;
			// The reading is scaled before any compare, so set values are in the same units.
			assign scaled = raw * ratio; // see [R3]
			// Each channel picks its output on its own, so both may watch the same output.
			assign active = current_sense_fitted & ((asg == `ASSIGN_OUT_ONE) | (asg == `ASSIGN_OUT_TWO)); // see [R4] [R6] [R8]
			assign out_on = (asg == `ASSIGN_OUT_ONE) ? control_output_one : control_output_two;
			assign mv = (asg == `ASSIGN_OUT_ONE) ? mv_one : mv_two;
			// Cross-multiplied to avoid a divider: current times 100 against set value times output percent.
			assign meas_pct = scaled * `MV_FULL; // see [R10]
			assign expect_pct = setv * mv; // see [R10]
			// Type A counts a sample in range only while the pulsed output is on; a sample taken while it is off restarts the count.
			assign in_range = active & ((type_ff[i] == `TYPE_B) ? (meas_pct < expect_pct) : (out_on & (scaled < setv))); // see [R9] [R10]
			assign cnt_inc = {1'b0, cnt_ff} + {{`DELAY_W{1'b0}}, 1'b1};

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt_ff <= {`DELAY_W{1'b0}};
					alarm_ff <= 1'b0;
				end else if (!active) begin
					cnt_ff <= {`DELAY_W{1'b0}};
					alarm_ff <= 1'b0;
				end else if (alarm_tick) begin
					if (!in_range) begin
						cnt_ff <= {`DELAY_W{1'b0}}; // see [R12]
						alarm_ff <= 1'b0;
					end else begin
						if (cnt_inc >= {1'b0, need}) begin
							alarm_ff <= 1'b1; // see [R1] [R12]
						end
						// The count saturates so a long fault cannot wrap it round.
						if (!cnt_inc[`DELAY_W]) begin
							cnt_ff <= cnt_inc[`DELAY_W-1:0];
						end
					end
				end
			end

			// The delayed copy marks the rising edge that sets the sticky status bit.
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					alarm_d_ff <= 1'b0;
				end else begin
					alarm_d_ff <= alarm_ff;
				end
			end

			assign alarm_vec[i] = alarm_ff;
			assign cnt_vec[i*`DELAY_W +: `DELAY_W] = cnt_ff;
			assign rise_vec[i] = alarm_ff & ~alarm_d_ff;
		end
	endgenerate

	assign heater_fault_alarm_one = alarm_vec[0];
	assign heater_fault_alarm_two = alarm_vec[1];

	// Physical alarm paths exist only on the second control output and the optional digital output.
	wire nxt_alarm_to_output_two;
	wire nxt_alarm_to_digital;
	assign nxt_alarm_to_output_two = (alarm_vec[0] & (assign_one_ff == `ASSIGN_OUT_TWO)) |
		(alarm_vec[1] & (assign_two_ff == `ASSIGN_OUT_TWO)); // see [R5] [R8]
	assign nxt_alarm_to_digital = digital_output_fitted & (alarm_vec[0] | alarm_vec[1]); // see [R8]
	// A register stage keeps the physical drives free of glitches from the compare logic.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_to_output_two_ff <= 1'b0;
			alarm_to_digital_ff <= 1'b0;
		end else begin
			alarm_to_output_two_ff <= nxt_alarm_to_output_two;
			alarm_to_digital_ff <= nxt_alarm_to_digital;
		end
	end

	// A rising alarm in the same cycle as its clear keeps the bit set.
	wire [1:0] nxt_irq_stat;
	assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | rise_vec;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_ff <= 2'h0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	assign irq = |(irq_stat_ff & irq_en_ff);

endmodule // heater_break_alarm_qualifier

// file: testbench.sv
// Self-checking bench for the heater-break alarm qualifier over AHB-Lite.
// Assumes the design files and hba_qual_defs.vh are compiled alongside.
`timescale 1ns/1ps
`include "hba_qual_defs.vh"
module testbench;
	reg hclk, hresetn, hwrite, run, on_two, fitted, dfit, cont2;
	reg [6:0] mv2;
	reg [1:0] htrans;
	reg [31:0] haddr, hwdata, q;
	reg [11:0] raw_one, raw_two;
	wire hreadyout, hresp, tick, c2, a1, a2, o2, dg, irq;
	wire [31:0] hrdata;
	wire [11:0] ct1, ct2;
	integer mismatches, total_checks, n;
	heater_break_alarm_qualifier heater_break_alarm_qualifier_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_tick(tick), .current_sense_input_one(ct1),
		.current_sense_input_two(ct2), .control_output_one(1'b0), .control_output_two(c2), .mv_one(7'h32),
		.mv_two(mv2), .out_one_continuous(1'b0), .out_two_continuous(cont2), .current_sense_fitted(fitted),
		.digital_output_fitted(dfit), .heater_fault_alarm_one(a1), .heater_fault_alarm_two(a2),
		.alarm_to_output_two_ff(o2), .alarm_to_digital_ff(dg), .irq(irq));
	ct_channel_model ct_channel_model_i (.hclk(hclk), .hresetn(hresetn), .run(run), .raw_one(raw_one),
		.raw_two(raw_two), .on_two(on_two), .sample_tick(tick), .current_sense_input_one(ct1),
		.current_sense_input_two(ct2), .control_output_two(c2));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task finish_test;
		begin
			if (mismatches == 0 && total_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wait_rdy;
		integer i;
		begin
			i = 0;
			@(posedge hclk);
			while (hreadyout !== 1'b1) begin
				i = i + 1;
				if (i > 50) begin
					mismatches = mismatches + 1;
					finish_test;
				end
				@(posedge hclk);
			end
		end
	endtask
	// A whole single transfer; read data is taken at the data-phase edge.
	task bus(input [7:0] a, input w, input [31:0] d);
		begin
			haddr <= {24'h0, a};
			htrans <= 2'b10;
			hwrite <= w;
			wait_rdy;
			htrans <= 2'b00;
			hwdata <= d;
			wait_rdy;
			q = hrdata;
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		begin
			bus(a, 1'b0, 32'h0);
			check(q, exp);
		end
	endtask
	task tick_wait;
		integer i;
		begin
			i = 0;
			@(posedge hclk);
			while (tick !== 1'b1) begin
				i = i + 1;
				if (i > 50) begin
					mismatches = mismatches + 1;
					finish_test;
				end
				@(posedge hclk);
			end
			repeat (2) @(posedge hclk);
		end
	endtask
	initial begin
		mismatches = 0;
		total_checks = 0;
		hresetn = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		run = 1'b0;
		on_two = 1'b1;
		fitted = 1'b1;
		dfit = 1'b1;
		cont2 = 1'b1;
		mv2 = 7'h32;
		raw_one = 12'h001;
		raw_two = 12'h001;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`OFS_RATIO_ONE, 32'h00000320);
		rd(`OFS_ASSIGN, 32'h00000001);
		rd(`OFS_TYPE, 32'h00000000);
		rd(`OFS_DELAY, 32'h00000505);
		rd(8'h40, 32'h00000000);
		bus(`OFS_RATIO_TWO, 1'b1, 32'h0000270F);
		rd(`OFS_RATIO_TWO, 32'h0000270F);
		bus(`OFS_ASSIGN, 1'b1, 32'h00000022);
		rd(`OFS_TYPE, 32'h00000003);
		bus(`OFS_ASSIGN, 1'b1, 32'h00000021);
		rd(`OFS_TYPE, 32'h00000002);
		bus(`OFS_ASSIGN, 1'b1, 32'h00000000);
		rd(`OFS_TYPE, 32'h00000000);
		bus(`OFS_RATIO_TWO, 1'b1, 32'h00000320);
		cont2 <= 1'b0;
		bus(`OFS_ASSIGN, 1'b1, 32'h00000022);
		rd(`OFS_TYPE, 32'h00000000);
		bus(`OFS_TYPE, 1'b1, 32'h00000000);
		bus(`OFS_DELAY, 1'b1, 32'h00000002);
		bus(`OFS_SETV_ONE, 1'b1, 32'h000003E8);
		bus(`OFS_SETV_TWO, 1'b1, 32'h000003E8);
		bus(`OFS_IRQ_EN, 1'b1, 32'h00000003);
		run <= 1'b1;
		// Only even ticks are judged, so alarm two with count 0 rises at tick 2 and alarm one at tick 4.
		for (n = 1; n <= 4; n = n + 1) begin
			tick_wait;
			check(a1, n >= 4);
			check(a2, n >= 2);
			check(o2, n >= 2);
			check(dg, n >= 2);
		end
		check(irq, 1'b1);
		rd(`OFS_IRQ_STAT, 32'h00000003);
		bus(`OFS_IRQ_EN, 1'b1, 32'h00000000);
		@(posedge hclk);
		check(irq, 1'b0);
		bus(`OFS_IRQ_CLR, 1'b1, 32'h00000001);
		rd(`OFS_IRQ_STAT, 32'h00000002);
		raw_one <= 12'h002;
		repeat (2) tick_wait;
		check(a1, 1'b0);
		check(a2, 1'b1);
		dfit <= 1'b0;
		repeat (2) @(posedge hclk);
		check(dg, 1'b0);
		check(o2, 1'b1);
		fitted <= 1'b0;
		repeat (2) @(posedge hclk);
		check(a2, 1'b0);
		// Type B on alarm two: 800 x 100 is not below 1000 x 50, but is below 1000 x 100.
		bus(`OFS_TYPE, 1'b1, 32'h00000002);
		fitted <= 1'b1;
		repeat (2) tick_wait;
		check(a2, 1'b0);
		check(a1, 1'b0);
		mv2 <= 7'h64;
		repeat (2) tick_wait;
		check(a2, 1'b1);
		finish_test;
	end
endmodule // testbench
